// ### inc/rdc_defines.vh
`ifndef RDC_DEFINES_VH
`define RDC_DEFINES_VH

// Five resolved levels of a strap input
`define RDC_LVL0 3'h0
`define RDC_LVL1 3'h1
`define RDC_LVL2 3'h2
`define RDC_LVL3 3'h3
`define RDC_LVL4 3'h4

// Channel window: ADDR[4]=0, ADDR[3:2]=channel, ADDR[1:0]=field
`define RDC_FLD_BOOST  2'h0
`define RDC_FLD_SHAPE  2'h1
`define RDC_FLD_DETECT 2'h2
`define RDC_ADDR_STATUS 5'h10
`define RDC_ADDR_STRAPS 5'h11

// Field positions
`define RDC_BOOST_ST1_LSB 0
`define RDC_BOOST_ST2_LSB 4
`define RDC_BOOST_SKIP    7
`define RDC_SHAPE_PRF_LSB 0
`define RDC_SHAPE_GN_LSB  4
`define RDC_DET_TRIG      0

// Reset values
`define RDC_RST_BOOST 8'h00
`define RDC_RST_SHAPE 8'h50
`define RDC_RST_RDATA 8'h00

// Consecutive valid detections needed per policy
`define RDC_NEED_L1 2'h3
`define RDC_NEED_L2 2'h2
`define RDC_NEED_L4 2'h1

// Timing
`define RDC_CLK_PERIOD_NS 20
`define RDC_POLL_TIME_US  150

`endif

// ### src/rdc_level_decode.v
`timescale 1ns/1ps
`include "rdc_defines.vh"

// Turns the comparator ladder of one five-level strap into a level number
module rdc_level_decode (
  input  wire [3:0] thermo,
  output reg  [2:0] level
);

  // Highest tripped comparator wins, so a glitchy lower bit cannot lower the level
  always @* begin
    casez (thermo)
      4'b1???: level = `RDC_LVL4; // Floating pin pulls above every threshold
      4'b01??: level = `RDC_LVL3;
      4'b001?: level = `RDC_LVL2;
      4'b0001: level = `RDC_LVL1;
      default: level = `RDC_LVL0;
    endcase
  end

endmodule // rdc_level_decode

// ### src/rdc_config_detect.v
// Overview of operation
// - Each five-level strap resolves to level zero through four; four means floating.
// - Boost, gain and detect-policy straps are captured once after power-up only.
// - Mode strap is followed continuously and the control mode re-evaluated.
// - Midband shape code writable only in register mode; strap mode uses table value.
// - Strap mode: one boost for all channels; register mode: per-channel boost.
// - Boost index equals five times high level plus low level, up to 24; indices 19 and above share one row.
// - Index maps to stage codes, shape code and skip bit set for indices 0-4.
// - Strap mode: gain strap sets all channels; register mode: per-channel gain code.
// - Gain levels 0,1,2,3,float map to codes 0,1,3,7,5.
// - Detect starts at power-up, on power-down or path-select event, or by write.
// - Pin events start all four channels; a register trigger starts one channel.
// - Power-down low and policy level zero: no detection, termination always 50 ohm.
// - Policy level one: keep polling, declare after three consecutive valid detections.
// - Policy level two: declare after two consecutive detections; level three reserved.
// - Floating policy: retry about every 150 us until termination is found.
// - Polling policies hold high impedance until detection, then switch to 50 ohm.
// - Power-down high resets channels, high impedance termination, standby.
// - Register mode when the mode strap resolves to level two, else straps.
`timescale 1ns/1ps
`include "rdc_defines.vh"

module rdc_config_detect #(
  parameter integer POLL_CYCLES = (`RDC_POLL_TIME_US * 1000) / `RDC_CLK_PERIOD_NS
) (
  input  wire        CLOCK,
  input  wire        RSTN,
  input  wire        CE,
  input  wire [3:0]  BOOST_LEVEL_HI_PIN,
  input  wire [3:0]  BOOST_LEVEL_LO_PIN,
  input  wire [3:0]  GAIN_LEVEL_PIN,
  input  wire [3:0]  CONFIG_MODE_PIN,
  input  wire [3:0]  DETECT_POLICY_PIN,
  input  wire        POWER_DOWN_PIN,
  input  wire        PATH_SELECT_PIN,
  input  wire [3:0]  FAR_END_TERM_SENSE,
  input  wire [4:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WSTB,
  input  wire        RSTB,
  output reg  [7:0]  RDATA,
  output wire [15:0] FIRST_BOOST_STAGE_CODE,
  output wire [11:0] SECOND_BOOST_STAGE_CODE,
  output wire [15:0] MIDBAND_SHAPE_CODE,
  output wire [3:0]  FIRST_STAGE_SKIP,
  output wire [11:0] FLAT_GAIN_CODE,
  output wire [3:0]  TERM_50_OHM,
  output wire [3:0]  DETECT_DONE,
  output reg         REG_MODE,
  output reg         STANDBY
);

  localparam [1:0]  ST_OFF    = 2'h0;
  localparam [1:0]  ST_POLL   = 2'h1;
  localparam [1:0]  ST_DONE   = 2'h2;
  localparam [1:0]  ST_BUFFER = 2'h3;
  localparam [12:0] POLL_LAST = POLL_CYCLES[12:0] - 13'h0001; // Timer is 13 bits wide, enough for 150 us

  wire [19:0] strap_pins;
  wire [14:0] strap_lvl;
  reg  [2:0]  boost_hi;
  reg  [2:0]  boost_lo;
  reg  [2:0]  gain_lvl;
  reg  [2:0]  policy_lvl;
  reg  [2:0]  mode_lvl;
  reg         captured;
  reg         pu_start;
  reg         pd_q;
  reg         sel_q;
  wire        pin_start;
  wire [4:0]  boost_index;
  wire [11:0] strap_row;
  wire [2:0]  strap_gain;
  reg  [1:0]  need;
  wire [31:0] all_boost;
  wire [31:0] all_shape;
  wire [31:0] all_detect;
  wire        chan_addr;
  wire [1:0]  addr_ch;
  reg  [7:0]  next_rdata;

  // Boost row packed as {skip, shape[3:0], stage2[2:0], stage1[3:0]}
  function [11:0] boost_row;
    input [4:0] idx;
    begin
      case (idx)
        5'h00:   boost_row = {1'h1, 4'h0, 3'h0, 4'h0};
        5'h01:   boost_row = {1'h1, 4'h0, 3'h0, 4'h1};
        5'h02:   boost_row = {1'h1, 4'h0, 3'h0, 4'h3};
        5'h03:   boost_row = {1'h1, 4'h0, 3'h0, 4'h7};
        5'h04:   boost_row = {1'h1, 4'h0, 3'h1, 4'h7};
        5'h05:   boost_row = {1'h0, 4'h1, 3'h0, 4'h0};
        5'h06:   boost_row = {1'h0, 4'h1, 3'h0, 4'h1};
        5'h07:   boost_row = {1'h0, 4'h1, 3'h0, 4'h2};
        5'h08:   boost_row = {1'h0, 4'h3, 3'h0, 4'h3};
        5'h09:   boost_row = {1'h0, 4'h3, 3'h0, 4'h4};
        5'h0a:   boost_row = {1'h0, 4'h7, 3'h1, 4'h5};
        5'h0b:   boost_row = {1'h0, 4'h7, 3'h1, 4'h6};
        5'h0c:   boost_row = {1'h0, 4'h7, 3'h1, 4'h8};
        5'h0d:   boost_row = {1'h0, 4'h7, 3'h1, 4'ha};
        5'h0e:   boost_row = {1'h0, 4'hf, 3'h2, 4'ha};
        5'h0f:   boost_row = {1'h0, 4'hf, 3'h3, 4'hb};
        5'h10:   boost_row = {1'h0, 4'hf, 3'h4, 4'hc};
        5'h11:   boost_row = {1'h0, 4'hf, 3'h5, 4'hd};
        5'h12:   boost_row = {1'h0, 4'hf, 3'h6, 4'he};
        default: boost_row = {1'h0, 4'hf, 3'h7, 4'hf}; // Index 19 and any overrange
      endcase
    end
  endfunction

  // Gain strap level to flat gain code
  function [2:0] gain_map;
    input [2:0] lvl;
    begin
      case (lvl)
        `RDC_LVL0: gain_map = 3'h0;
        `RDC_LVL1: gain_map = 3'h1;
        `RDC_LVL2: gain_map = 3'h3;
        `RDC_LVL3: gain_map = 3'h7;
        default:   gain_map = 3'h5;
      endcase
    end
  endfunction

  // One ladder decoder per strap pin
  assign strap_pins = {DETECT_POLICY_PIN, CONFIG_MODE_PIN, GAIN_LEVEL_PIN, BOOST_LEVEL_LO_PIN, BOOST_LEVEL_HI_PIN};

  genvar p;
  generate
    for (p = 0; p < 5; p = p + 1) begin : g_strap
      rdc_level_decode u_dec (
        .thermo (strap_pins[p*4 +: 4]),
        .level  (strap_lvl[p*3 +: 3])
      );
    end
  endgenerate

  // Sample-once straps are caught on the first enabled edge after reset release
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      boost_hi   <= `RDC_LVL0;
      boost_lo   <= `RDC_LVL0;
      gain_lvl   <= `RDC_LVL4;
      policy_lvl <= `RDC_LVL4;
      captured   <= 1'b0;
      pu_start   <= 1'b0;
    end else if (CE) begin
      pu_start <= 1'b0;
      if (!captured) begin
        boost_hi   <= strap_lvl[2:0];
        boost_lo   <= strap_lvl[5:3];
        gain_lvl   <= strap_lvl[8:6];
        policy_lvl <= strap_lvl[14:12];
        captured   <= 1'b1;
        pu_start   <= 1'b1;             // Power-up detect kick
      end
    end
  end

  // Mode strap is live, so the mode can flip while traffic runs
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      mode_lvl <= `RDC_LVL0;
      REG_MODE <= 1'b0;
      STANDBY  <= 1'b0;
      pd_q     <= 1'b0;
      sel_q    <= 1'b0;
    end else if (CE) begin
      mode_lvl <= strap_lvl[11:9];
      REG_MODE <= (strap_lvl[11:9] == `RDC_LVL2);
      STANDBY  <= POWER_DOWN_PIN;
      pd_q     <= POWER_DOWN_PIN;
      sel_q    <= PATH_SELECT_PIN;
    end
  end

  // Power-down release or a path-select flip restarts every channel
  assign pin_start = pu_start | (pd_q & ~POWER_DOWN_PIN) | (sel_q ^ PATH_SELECT_PIN);

  assign boost_index = {boost_hi[2:0], 2'h0} + {2'h0, boost_hi} + {2'h0, boost_lo};
  assign strap_row   = boost_row(boost_index);
  assign strap_gain  = gain_map(gain_lvl);

  // Reserved level three polls like floating: safest toward a link partner
  always @* begin
    case (policy_lvl)
      `RDC_LVL1: need = `RDC_NEED_L1;
      `RDC_LVL2: need = `RDC_NEED_L2;
      default:   need = `RDC_NEED_L4;
    endcase
  end

  assign chan_addr = ~ADDR[4];
  assign addr_ch   = ADDR[3:2];

  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_ch
      reg  [7:0]  boost_reg;
      reg  [7:0]  shape_reg;
      reg  [1:0]  st;
      reg  [12:0] tmr;
      reg  [1:0]  cnt;
      reg         term;
      reg         done_q;
      reg  [3:0]  o_st1;
      reg  [2:0]  o_st2;
      reg  [3:0]  o_prf;
      reg         o_skip;
      reg  [2:0]  o_gain;
      wire        wr_sel;
      wire        trig;
      wire [1:0]  cnt_inc;

      assign wr_sel  = WSTB & chan_addr & (addr_ch == c);
      assign trig    = wr_sel & (ADDR[1:0] == `RDC_FLD_DETECT) & WDATA[`RDC_DET_TRIG];
      assign cnt_inc = cnt + 2'h1;

      // Channel registers; the shape code is locked while straps rule
      always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          boost_reg <= `RDC_RST_BOOST;
          shape_reg <= `RDC_RST_SHAPE;
        end else if (CE) begin
          if (wr_sel && ADDR[1:0] == `RDC_FLD_BOOST)
            boost_reg <= WDATA;
          if (wr_sel && ADDR[1:0] == `RDC_FLD_SHAPE) begin
            shape_reg[7:4] <= {1'b0, WDATA[6:4]};
            if (REG_MODE)
              shape_reg[3:0] <= WDATA[3:0];
          end
        end
      end

      // Equalizer and gain drive, registered so outputs never glitch on mode change
      always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          o_st1  <= 4'h0;
          o_st2  <= 3'h0;
          o_prf  <= 4'h0;
          o_skip <= 1'b0;
          o_gain <= 3'h0;
        end else if (CE) begin
          if (REG_MODE) begin
            o_st1  <= boost_reg[`RDC_BOOST_ST1_LSB +: 4];
            o_st2  <= boost_reg[`RDC_BOOST_ST2_LSB +: 3];
            o_skip <= boost_reg[`RDC_BOOST_SKIP];
            o_prf  <= shape_reg[`RDC_SHAPE_PRF_LSB +: 4];
            o_gain <= shape_reg[`RDC_SHAPE_GN_LSB +: 3];
          end else begin
            o_st1  <= strap_row[3:0];
            o_st2  <= strap_row[6:4];
            o_prf  <= strap_row[10:7];
            o_skip <= strap_row[11];
            o_gain <= strap_gain;
          end
        end
      end

      // Far-end termination detect, one independent machine per channel
      always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          st   <= ST_OFF;
          tmr  <= 13'h0000;
          cnt  <= 2'h0;
          term <= 1'b0;
          done_q <= 1'b0;
        end else if (CE) begin
          if (POWER_DOWN_PIN) begin
            st   <= ST_OFF;
            tmr  <= 13'h0000;
            cnt  <= 2'h0;
            term <= 1'b0;
            done_q <= 1'b0;
          end else if (captured && policy_lvl == `RDC_LVL0) begin
            st   <= ST_BUFFER;
            cnt  <= 2'h0;
            term <= 1'b1;
            done_q <= 1'b0;
          end else if (pin_start || trig) begin
            st   <= ST_POLL;
            tmr  <= 13'h0000;
            cnt  <= 2'h0;
            term <= 1'b0;
            done_q <= 1'b0;
          end else begin
            case (st)
              ST_POLL: begin
                if (tmr == POLL_LAST) begin
                  tmr <= 13'h0000;
                  if (FAR_END_TERM_SENSE[c]) begin
                    if (cnt_inc >= need) begin
                      st   <= ST_DONE;
                      term <= 1'b1;
                      done_q <= 1'b1;  // Flag kept in its own flop so the port never glitches
                    end else
                      cnt <= cnt_inc;
                  end else
                    cnt <= 2'h0;
                end else
                  tmr <= tmr + 13'h0001;
              end
              ST_DONE:   term <= 1'b1;
              ST_BUFFER: st <= ST_OFF; // Policy left level zero, wait for a start
              default:   term <= 1'b0;
            endcase
          end
        end
      end

      assign FIRST_BOOST_STAGE_CODE[c*4 +: 4]  = o_st1;
      assign SECOND_BOOST_STAGE_CODE[c*3 +: 3] = o_st2;
      assign MIDBAND_SHAPE_CODE[c*4 +: 4]      = o_prf;
      assign FIRST_STAGE_SKIP[c]               = o_skip;
      assign FLAT_GAIN_CODE[c*3 +: 3]          = o_gain;
      assign TERM_50_OHM[c]                    = term;
      assign DETECT_DONE[c]                    = done_q;
      assign all_boost[c*8 +: 8]  = boost_reg;
      assign all_shape[c*8 +: 8]  = shape_reg;
      assign all_detect[c*8 +: 8] = {2'h0, term, st, cnt, 1'b0}; // Trigger bit reads zero
    end
  endgenerate

  // Read mux; unmapped addresses answer zero
  always @* begin
    next_rdata = `RDC_RST_RDATA;
    if (chan_addr) begin
      case (ADDR[1:0])
        `RDC_FLD_BOOST:  next_rdata = all_boost[addr_ch*8 +: 8];
        `RDC_FLD_SHAPE:  next_rdata = all_shape[addr_ch*8 +: 8];
        `RDC_FLD_DETECT: next_rdata = all_detect[addr_ch*8 +: 8];
        default:         next_rdata = `RDC_RST_RDATA;
      endcase
    end else if (ADDR == `RDC_ADDR_STATUS)
      next_rdata = {STANDBY, REG_MODE, policy_lvl, mode_lvl};
    else if (ADDR == `RDC_ADDR_STRAPS)
      next_rdata = {gain_lvl[1:0], boost_lo, boost_hi};
  end

  // Read data stands for exactly one cycle after the strobe
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      RDATA <= `RDC_RST_RDATA;
    else if (CE)
      RDATA <= RSTB ? next_rdata : `RDC_RST_RDATA;
  end

endmodule // rdc_config_detect

// ### verif/rdc_config_detect_props.sv
`timescale 1ns/1ps
// Watches strap codes, mode selection and termination control at the top ports
module rdc_config_detect_props (
  input wire        CLOCK,
  input wire        RSTN,
  input wire        POWER_DOWN_PIN,
  input wire [3:0]  CONFIG_MODE_PIN,
  input wire [15:0] FIRST_BOOST_STAGE_CODE,
  input wire [11:0] SECOND_BOOST_STAGE_CODE,
  input wire [15:0] MIDBAND_SHAPE_CODE,
  input wire [3:0]  FIRST_STAGE_SKIP,
  input wire [11:0] FLAT_GAIN_CODE,
  input wire [3:0]  TERM_50_OHM,
  input wire [3:0]  DETECT_DONE,
  input wire        REG_MODE,
  input wire        STANDBY
);
  reg  [2:0] since_rst;
  reg  [1:0] strap_age;
  wire       settled;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // Ages keep checks off cycles where reset release or a mode swap is still settling
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      since_rst <= 3'h0;
      strap_age <= 2'h0;
    end else begin
      since_rst <= (since_rst == 3'h7) ? 3'h7 : since_rst + 3'h1;
      strap_age <= REG_MODE ? 2'h0 : ((strap_age == 2'h3) ? 2'h3 : strap_age + 2'h1);
    end
  end
  assign settled = (since_rst == 3'h7) && (strap_age == 2'h3);
  AST_STANDBY_LAG: assert property ((since_rst != 3'h0) |-> STANDBY == $past(POWER_DOWN_PIN))
    else $error("standby does not follow power down");
  AST_PD_HIZ: assert property ((since_rst != 3'h0) && POWER_DOWN_PIN |=> TERM_50_OHM == 4'h0 && DETECT_DONE == 4'h0)
    else $error("termination not released in power down");
  AST_DONE_TERM: assert property ((DETECT_DONE & ~TERM_50_OHM) == 4'h0)
    else $error("detected channel without 50 ohm termination");
  AST_SKIP_ROWS: assert property (settled && FIRST_STAGE_SKIP[0] |->
    MIDBAND_SHAPE_CODE[3:0] == 4'h0 && SECOND_BOOST_STAGE_CODE[2:0] <= 3'h1)
    else $error("skip bit outside lowest boost rows");
  AST_SAME_BOOST: assert property (settled |-> FIRST_BOOST_STAGE_CODE == {4{FIRST_BOOST_STAGE_CODE[3:0]}}
    && SECOND_BOOST_STAGE_CODE == {4{SECOND_BOOST_STAGE_CODE[2:0]}})
    else $error("strap boost differs between channels");
  AST_SAME_GAIN: assert property (settled |-> FLAT_GAIN_CODE == {4{FLAT_GAIN_CODE[2:0]}})
    else $error("strap gain differs between channels");
  AST_SHAPE_HOLD: assert property (settled |-> $stable(MIDBAND_SHAPE_CODE))
    else $error("shape code moved in strap mode");
  AST_BOOST_HOLD: assert property (settled |-> $stable(FIRST_BOOST_STAGE_CODE) && $stable(FIRST_STAGE_SKIP))
    else $error("boost code moved after capture");
  AST_MODE_ON: assert property ((since_rst == 3'h7 && CONFIG_MODE_PIN == 4'h3) [*4] |-> REG_MODE)
    else $error("register mode not entered");
  AST_MODE_OFF: assert property ((since_rst == 3'h7 && CONFIG_MODE_PIN != 4'h3) [*4] |-> !REG_MODE)
    else $error("register mode not left");
  // Main scenarios reached
  cover property (DETECT_DONE == 4'hf);
  cover property (STANDBY && settled);
  cover property (REG_MODE);
endmodule // rdc_config_detect_props

bind rdc_config_detect rdc_config_detect_props rdc_config_detect_props_inst (.CLOCK(CLOCK), .RSTN(RSTN),
  .POWER_DOWN_PIN(POWER_DOWN_PIN), .CONFIG_MODE_PIN(CONFIG_MODE_PIN),
  .FIRST_BOOST_STAGE_CODE(FIRST_BOOST_STAGE_CODE), .SECOND_BOOST_STAGE_CODE(SECOND_BOOST_STAGE_CODE),
  .MIDBAND_SHAPE_CODE(MIDBAND_SHAPE_CODE), .FIRST_STAGE_SKIP(FIRST_STAGE_SKIP), .FLAT_GAIN_CODE(FLAT_GAIN_CODE),
  .TERM_50_OHM(TERM_50_OHM), .DETECT_DONE(DETECT_DONE), .REG_MODE(REG_MODE), .STANDBY(STANDBY));

// ### verif/rdc_far_end_model.sv
`timescale 1ns/1ps
// Far-end receivers: a fitted card loads its lane for as long as it sits in the slot
module rdc_far_end_model (
  input  wire [3:0] card_present_signal,
  output wire [3:0] term_sense
);
  // Termination is a static load, so a probe sees it at any moment the card is fitted
  assign term_sense = card_present_signal;
endmodule // rdc_far_end_model

// ### verif/tb_rdc_config_detect.sv
`timescale 1ns/1ps
module tb_rdc_config_detect;
  localparam integer N = 8;
  reg         clk = 1'b0, rstn = 1'b0, pd = 1'b0, sel = 1'b0, wstb = 1'b0, rstb = 1'b0, ce = 1'b1;
  reg  [3:0]  hi = 4'h0, lo = 4'h0, gain = 4'h0, mode = 4'h0, pol = 4'h0, present = 4'h0;
  reg  [4:0]  addr = 5'h00;
  reg  [7:0]  wdata = 8'h00;
  wire [7:0]  rdata;
  wire [15:0] st1, prf;
  wire [11:0] st2, flat;
  wire [3:0]  skip, term, done, sense;
  wire        regm, stby;
  integer     err_total = 0, n_tests = 0, cyc = 0;
  reg  [2:0]  thi [0:4] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3};
  reg  [2:0]  tlo [0:4] = '{3'h0, 3'h4, 3'h0, 3'h4, 3'h4};
  reg  [3:0]  ts1 [0:4] = '{4'h0, 4'h7, 4'h0, 4'ha, 4'hf};
  reg  [2:0]  ts2 [0:4] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h7};
  reg  [3:0]  tpr [0:4] = '{4'h0, 4'h0, 4'h1, 4'hf, 4'hf};
  reg  [0:0]  tsk [0:4] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
  reg  [2:0]  tgc [0:4] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h5};

  rdc_config_detect #(.POLL_CYCLES(N)) rdc_config_detect_inst (.CLOCK(clk), .RSTN(rstn), .CE(ce),
    .BOOST_LEVEL_HI_PIN(hi), .BOOST_LEVEL_LO_PIN(lo), .GAIN_LEVEL_PIN(gain), .CONFIG_MODE_PIN(mode),
    .DETECT_POLICY_PIN(pol), .POWER_DOWN_PIN(pd), .PATH_SELECT_PIN(sel), .FAR_END_TERM_SENSE(sense),
    .ADDR(addr), .WDATA(wdata), .WSTB(wstb), .RSTB(rstb), .RDATA(rdata), .FIRST_BOOST_STAGE_CODE(st1),
    .SECOND_BOOST_STAGE_CODE(st2), .MIDBAND_SHAPE_CODE(prf), .FIRST_STAGE_SKIP(skip), .FLAT_GAIN_CODE(flat),
    .TERM_50_OHM(term), .DETECT_DONE(done), .REG_MODE(regm), .STANDBY(stby));
  rdc_far_end_model rdc_far_end_model_inst (.card_present_signal(present), .term_sense(sense));

  // Clock and a watchdog well above the expected run length
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      close_out;
    end
  end

  // Thermometer pattern a resistor strap of the given level produces
  function [3:0] lv(input [2:0] l);
    lv = 4'hf >> (3'h4 - l);
  endfunction

  task chk(input string nm, input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task tick(input integer k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Boost, gain and policy straps only count at power-up, so each setting needs its own reset
  task boot(input [2:0] h, input [2:0] l, input [2:0] g, input [2:0] p, input [3:0] pr);
    @(posedge clk);
    rstn <= 1'b0;
    hi <= lv(h);
    lo <= lv(l);
    gain <= lv(g);
    pol <= lv(p);
    present <= pr;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
  endtask

  task wr(input [4:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask

  task rdchk(input string nm, input [4:0] a, input [7:0] exp);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask

  // Every boost row class and gain level, then strap changes that must be ignored
  task t_table;
    integer i, p;
    for (i = 0; i < 5; i = i + 1) begin
      boot(thi[i], tlo[i], i[2:0], 3'h0, 4'hf);
      for (p = 0; p < 2; p = p + 1) begin
        tick(6);
        chk("boost1", st1, {4{ts1[i]}});
        chk("boost2", st2, {4{ts2[i]}});
        chk("shape", prf, {4{tpr[i]}});
        chk("skip", skip, {4{tsk[i]}});
        chk("gain", flat, {4{tgc[i]}});
        chk("buffer term", {done, term}, 8'h0f);
        @(posedge clk);
        hi <= lv(3'h4);
        gain <= lv(3'h3);
        pol <= lv(3'h4);
      end
    end
    $display("table test done");
  endtask

  // Two-hit policy, then per-channel trigger, path select and power-down restarts
  task t_l2;
    boot(3'h3, 3'h4, 3'h4, 3'h2, 4'h7);
    tick(N + 4);
    chk("one hit", {done, term}, 8'h00);
    tick(N);
    chk("two hits", {done, term}, 8'h77);
    wr(5'h0a, 8'h01);
    tick(2);
    chk("trigger ch2", term, 4'h3);
    tick(2 * N + 2);
    chk("trigger redone", term, 4'h7);
    @(posedge clk);
    sel <= ~sel;
    tick(3);
    chk("path select", term, 4'h0);
    tick(2 * N + 2);
    chk("path redone", term, 4'h7);
    @(posedge clk);
    pd <= 1'b1;
    tick(10000);
    chk("standby", {stby, done, term}, 9'h100);
    @(posedge clk);
    pd <= 1'b0;
    tick(2 * N + 4);
    chk("pd redone", term, 4'h7);
    $display("two-hit test done");
  endtask

  // Three-hit policy; a missed hit on channel 0 clears its count
  task t_l1;
    boot(3'h3, 3'h4, 3'h4, 3'h1, 4'hf);
    tick(N + 4);
    @(posedge clk);
    present <= 4'he;
    tick(N);
    chk("two of three", done, 4'h0);
    @(posedge clk);
    present <= 4'hf;
    tick(5);
    chk("miss clears", done, 4'he);
    tick(16);
    chk("late done", done, 4'hf);
    $display("three-hit test done");
  endtask

  // Floating policy retries each poll period until the card turns up
  task t_float;
    boot(3'h3, 3'h4, 3'h4, 3'h4, 4'h7);
    tick(N + 4);
    chk("float first", {done, term}, 8'h77);
    @(posedge clk);
    present <= 4'hf;
    tick(N + 2);
    chk("float retry", {done, term}, 8'hff);
    $display("float test done");
  endtask

  // Register mode switching and per-channel overrides
  task t_regs;
    wr(5'h01, 8'h5a);
    rdchk("shape locked", 5'h01, 8'h50);
    @(posedge clk);
    mode <= lv(3'h2);
    tick(4);
    chk("reg mode", regm, 1'h1);
    wr(5'h01, 8'h3a);
    wr(5'h04, 8'h9c);
    tick(2);
    chk("ch0 shape", prf[3:0], 4'ha);
    chk("ch0 gain", flat[2:0], 3'h3);
    chk("ch2 gain", flat[8:6], 3'h5);
    chk("ch1 boost", {skip[1], st2[5:3], st1[7:4]}, 8'h9c);
    chk("ch0 boost", {skip[0], st2[2:0], st1[3:0]}, 8'h00);
    rdchk("ch1 boost rd", 5'h04, 8'h9c);
    rdchk("unmapped", 5'h1f, 8'h00);
    @(posedge clk);
    mode <= lv(3'h0);
    tick(4);
    chk("strap mode", regm, 1'h0);
    chk("ch1 strap", {skip[1], st2[5:3], st1[7:4]}, 8'h7f);
    $display("register test done");
  endtask

  // A low clock enable freezes the block, so a strobe in that window is lost
  task t_ce;
    @(posedge clk);
    ce <= 1'b0;
    wr(5'h00, 8'h11);
    @(posedge clk);
    ce <= 1'b1;
    rdchk("ce lost write", 5'h00, 8'h00);
    $display("enable test done");
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    t_table;
    t_l2;
    t_l1;
    t_float;
    t_regs;
    t_ce;
    close_out;
  end
endmodule // tb_rdc_config_detect
